// *** include/mbfs_pkg.sv ***
package mbfs_pkg;
  // ********
  // Timing
  // ********
  localparam int CLK_PERIOD_NS = 8;
  localparam int ILIM_FILTER_NS = 3000;
  localparam int ILIM_FILTER_CYC = (ILIM_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVC_FILTER_NS = 2000;
  localparam int OVC_FILTER_CYC = (OVC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLF_DEGLITCH_MS = 275;
  localparam int CLF_DEGLITCH_CYC = CLF_DEGLITCH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RAMP_FULL_MS = 12;
  localparam int RAMP_STEPS = 255;
  localparam int RAMP_STEP_CYC = RAMP_FULL_MS * 1000000 / CLK_PERIOD_NS / RAMP_STEPS;
  localparam int PWM_FREQ_HZ = 44500;
  localparam int PWM_PERIOD_CYC = 1000000000 / (CLK_PERIOD_NS * PWM_FREQ_HZ);
  localparam int WAKE_PULSE_NS = 1000;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********
  // Widths
  // ********
  localparam int TIMER_W = 32;
  localparam int PWM_CNT_W = 12;
  localparam int DUTY_W = 8;
  localparam int PROD_W = PWM_CNT_W + DUTY_W;
  localparam int RAMP_CNT_W = 24;
  localparam int WAKE_W = 7;
  localparam int APB_ADDR_W = 8;
  localparam int GATE_W = 4;
  localparam int PIN_W = 9;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;

  // ********
  // Registers
  // ********
  localparam logic [APB_ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [APB_ADDR_W-1:0] REG_STATUS_OFS = 8'h04;
  localparam logic [APB_ADDR_W-1:0] REG_DUTY_OFS = 8'h08;
  localparam logic [DUTY_W-1:0] CTRL_SETPOINT_RST = 8'hff;
  localparam int STAT_CLF_BIT = 0;
  localparam int STAT_OVC_BIT = 1;
  localparam int STAT_SRC_LSB = 2;
  localparam int STAT_THERM_BIT = 6;
  localparam int STAT_LIMIT_BIT = 7;
  localparam int STAT_ACTIVE_BIT = 8;
  localparam int STAT_LOW_BIT = 9;

  // ********
  // Gate patterns: [3] high A, [2] low A, [1] high B, [0] low B
  // ********
  localparam logic [GATE_W-1:0] GATE_OFF = 4'h0;
  localparam logic [GATE_W-1:0] GATE_FWD = 4'h9;
  localparam logic [GATE_W-1:0] GATE_REV = 4'h6;
  localparam logic [GATE_W-1:0] GATE_RECIRC = 4'ha;
  localparam logic [GATE_W-1:0] GATE_BRAKE = 4'h5;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_FWD, MODE_REV, MODE_BRAKE} mbfs_mode_type;
endpackage

// *** core/mbfs_sync.sv ***
`timescale 1ns/1ps
module mbfs_sync
  import mbfs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } mbfs_sync_state_type;

  mbfs_sync_state_type s_reg;
  mbfs_sync_state_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = async_i;
    s_next.stab = s_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stab;
endmodule

// *** core/mbfs_persist.sv ***
`timescale 1ns/1ps
module mbfs_persist
  import mbfs_pkg::*;
#(
  parameter int LIMIT = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level and qualified result
  input wire logic level_i,
  output logic hold_o
);
  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic hold;
  } mbfs_persist_state_type;

  mbfs_persist_state_type s_reg;
  mbfs_persist_state_type s_next;

  // Hold rises after LIMIT consecutive high cycles, drops at once
  always_comb begin
    s_next = s_reg;
    if (!level_i) begin
      s_next.cnt = '0;
      s_next.hold = 1'b0;
    end else if (s_reg.cnt == TIMER_W'(LIMIT - 1)) begin
      s_next.hold = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hold_o = s_reg.hold;
endmodule

// *** core/mbfs_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Sense above limit for over 3 us steps bridge duty down.
// [RQ2] Current-limit fault reported only after 275 ms of continuous limiting.
// [RQ3] Bridge keeps driving under current limiting while that fault shows.
// [RQ4] Current-limit fault releases by itself when limiting stops.
// [RQ5] Sustained transistor clamp disables all gates and lowers the indicator.
// [RQ6] Overcurrent shutdown stays latched until supply returns; inputs cannot clear it.
// [RQ7] Each transistor clamp is filtered and detected on its own.
// [RQ8] Overcurrent path is separate from the current-limit path.
// [RQ9] Over-temperature disables gates, lowers indicator, recovers automatically.
// [RQ10] Supply low disables all, lowers indicator, resets logic; resumes after.
// [RQ11] Active when either direction input high; both low means sleep.
// [RQ12] Overcurrent and thermal shutdown leave internal logic running.
// [RQ13] Host should hold both direction inputs low while supply is off.
// [RQ14] Overcurrent filter time is about 2 us.
// [RQ15] Sleep clears a pending current-limit fault.
// [RQ16] Every exit from sleep pulses the indicator low briefly.
// [RQ17] Duty restarts at zero and ramps up over 12 ms.
// [RQ18] Indicator is low while any fault source or wake pulse is active.
module mbfs_top
  import mbfs_pkg::*;
#(
  parameter int CLF_FAULT_CYC = CLF_DEGLITCH_CYC,
  parameter int RAMP_TICK_CYC = RAMP_STEP_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [APB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Direction inputs
  input wire logic DIRECTION_INPUT_A_I,
  input wire logic DIRECTION_INPUT_B_I,
  // Sense comparators
  input wire logic CURRENT_SENSE_NODE_I,
  input wire logic [GATE_W-1:0] FET_CLAMP_I,
  input wire logic THERMAL_SHUTDOWN_I,
  input wire logic SUPPLY_LOW_LOCKOUT_I,
  // Bridge and indicator
  output logic [GATE_W-1:0] GATE_O,
  output logic ERROR_INDICATOR_N_O
);
  // ********
  // State
  // ********
  typedef struct packed {
    logic [DUTY_W-1:0] setpoint;
    logic [DUTY_W-1:0] duty;
    logic [PWM_CNT_W-1:0] pwm_cnt;
    logic [RAMP_CNT_W-1:0] ramp_cnt;
    logic ovc_latch;
    logic [GATE_W-1:0] ovc_src;
    logic active_d;
    logic [WAKE_W-1:0] wake_cnt;
    logic [GATE_W-1:0] gates;
    logic err_n;
    logic [31:0] rdata;
    logic slverr;
  } mbfs_top_state_type;

  localparam mbfs_top_state_type ST_RST = '{
    setpoint: CTRL_SETPOINT_RST,
    err_n: 1'b1,
    default: '0
  };

  mbfs_top_state_type s_reg;
  mbfs_top_state_type s_next;

  logic [PIN_W-1:0] pins_q;
  logic [1:0] dir_q;
  logic sense_q;
  logic [GATE_W-1:0] fet_q;
  logic therm_q;
  logic low_q;
  logic int_rst;
  logic limit_q;
  logic clf;
  logic [GATE_W-1:0] ovc_hit;
  logic ovc_set;
  mbfs_mode_type mode;
  logic active;
  logic pwm_wrap;
  logic ramp_tick;
  logic [PROD_W-1:0] duty_prod;
  logic pwm_on;
  logic drive_ok;
  logic setup;
  logic access;
  logic [31:0] status_word;

  // ********
  // Decoding
  // ********
  function automatic mbfs_mode_type decode_mode(input logic a, input logic b);
    case ({a, b})
      2'b10: decode_mode = MODE_FWD;
      2'b01: decode_mode = MODE_REV;
      2'b11: decode_mode = MODE_BRAKE;
      default: decode_mode = MODE_SLEEP;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [APB_ADDR_W-1:0] addr);
    reg_mapped = (addr == REG_CTRL_OFS) || (addr == REG_STATUS_OFS) ||
                 (addr == REG_DUTY_OFS);
  endfunction

  // ********
  // Pin synchronisers
  // ********
  mbfs_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .async_i({DIRECTION_INPUT_A_I, DIRECTION_INPUT_B_I, CURRENT_SENSE_NODE_I,
              FET_CLAMP_I, THERMAL_SHUTDOWN_I, SUPPLY_LOW_LOCKOUT_I}),
    .sync_o(pins_q)
  );

  assign dir_q = pins_q[8:7];
  assign sense_q = pins_q[6];
  assign fet_q = pins_q[5:2];
  assign therm_q = pins_q[1];
  assign low_q = pins_q[0];
  // Lockout restarts every timer
  assign int_rst = RST_I || low_q; // [RQ10]

  // ********
  // Current limit qualification
  // ********
  mbfs_persist #(
    .LIMIT(ILIM_FILTER_CYC)
  ) u_ilim (
    .clk_i(SYS_CLK_I),
    .rst_i(int_rst),
    .level_i(sense_q), // [RQ1]
    .hold_o(limit_q)
  );

  // Sleep drops the level and so clears the fault
  mbfs_persist #(
    .LIMIT(CLF_FAULT_CYC)
  ) u_clf (
    .clk_i(SYS_CLK_I),
    .rst_i(int_rst),
    .level_i(limit_q && active), // [RQ15]
    .hold_o(clf) // [RQ2]
  );

  // ********
  // Overcurrent filters, one per transistor
  // ********
  generate
    for (genvar i = 0; i < GATE_W; i++) begin : g_ovc
      mbfs_persist #(
        .LIMIT(OVC_FILTER_CYC) // [RQ14]
      ) u_ovc (
        .clk_i(SYS_CLK_I),
        .rst_i(int_rst),
        .level_i(fet_q[i]), // [RQ7]
        .hold_o(ovc_hit[i])
      );
    end
  endgenerate

  // Independent of the sense comparator path
  assign ovc_set = s_reg.ovc_latch || (ovc_hit != '0); // [RQ8]

  // ********
  // Mode, PWM and bridge enable
  // ********
  assign mode = decode_mode(dir_q[1], dir_q[0]);
  assign active = mode != MODE_SLEEP; // [RQ11]
  assign pwm_wrap = s_reg.pwm_cnt == PWM_CNT_W'(PWM_PERIOD_CYC - 1);
  assign ramp_tick = s_reg.ramp_cnt == RAMP_CNT_W'(RAMP_TICK_CYC - 1);
  assign duty_prod = PROD_W'(s_reg.duty) * PROD_W'(PWM_PERIOD_CYC);
  assign pwm_on = (s_reg.duty == DUTY_FULL) ||
                  (s_reg.pwm_cnt < duty_prod[PROD_W-1:DUTY_W]);
  assign drive_ok = active // [RQ11]
                    && !ovc_set // [RQ5]
                    && !therm_q; // [RQ9]
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;

  always_comb begin
    status_word = '0;
    status_word[STAT_CLF_BIT] = clf;
    status_word[STAT_OVC_BIT] = s_reg.ovc_latch;
    status_word[STAT_SRC_LSB +: GATE_W] = s_reg.ovc_src;
    status_word[STAT_THERM_BIT] = therm_q;
    status_word[STAT_LIMIT_BIT] = limit_q;
    status_word[STAT_ACTIVE_BIT] = active;
    status_word[STAT_LOW_BIT] = low_q;
  end

  // ********
  // Next state
  // ********
  always_comb begin
    logic [31:0] keep_rdata;
    logic keep_err;
    keep_rdata = '0;
    keep_err = 1'b0;
    s_next = s_reg;
    s_next.pwm_cnt = pwm_wrap ? '0 : s_reg.pwm_cnt + 1'b1;
    s_next.ramp_cnt = ramp_tick ? '0 : s_reg.ramp_cnt + 1'b1;

    // Duty: restart, limit stepping, ramp toward setpoint
    if (mode == MODE_SLEEP || mode == MODE_BRAKE) begin
      s_next.duty = '0; // [RQ17]
    end else if (limit_q) begin
      if (pwm_wrap && s_reg.duty != '0) begin
        s_next.duty = s_reg.duty - 1'b1; // [RQ1]
      end
    end else if (ramp_tick) begin
      if (s_reg.duty < s_reg.setpoint) begin
        s_next.duty = s_reg.duty + 1'b1; // [RQ17]
      end else if (s_reg.duty > s_reg.setpoint) begin
        s_next.duty = s_reg.duty - 1'b1;
      end
    end

    // Shutdown latch, cleared only by reset or lockout
    s_next.ovc_latch = ovc_set; // [RQ6]
    s_next.ovc_src = s_reg.ovc_src | ovc_hit; // [RQ7]

    // Wake pulse on leaving sleep
    s_next.active_d = active;
    if (active && !s_reg.active_d) begin
      s_next.wake_cnt = WAKE_W'(WAKE_PULSE_CYC); // [RQ16]
    end else if (s_reg.wake_cnt != '0) begin
      s_next.wake_cnt = s_reg.wake_cnt - 1'b1;
    end

    // Gates; limiting only lowers duty, never stops the bridge
    if (!drive_ok) begin
      s_next.gates = GATE_OFF;
    end else begin
      case (mode)
        MODE_FWD: s_next.gates = pwm_on ? GATE_FWD : GATE_RECIRC; // [RQ3]
        MODE_REV: s_next.gates = pwm_on ? GATE_REV : GATE_RECIRC; // [RQ3]
        MODE_BRAKE: s_next.gates = GATE_BRAKE;
        default: s_next.gates = GATE_OFF;
      endcase
    end

    s_next.err_n = !(clf || ovc_set || therm_q || s_next.wake_cnt != '0); // [RQ18]

    // APB: read data and error prepared in setup phase
    if (setup) begin
      s_next.slverr = !reg_mapped(PADDR_I);
      case (PADDR_I)
        REG_CTRL_OFS: s_next.rdata = 32'(s_reg.setpoint);
        REG_STATUS_OFS: s_next.rdata = status_word;
        REG_DUTY_OFS: s_next.rdata = 32'(s_reg.duty);
        default: s_next.rdata = '0;
      endcase
    end
    if (access && PWRITE_I && PADDR_I == REG_CTRL_OFS) begin
      s_next.setpoint = PWDATA_I[DUTY_W-1:0];
    end

    // Only lockout resets internal logic; bus answer survives
    if (low_q) begin // [RQ12]
      keep_rdata = s_next.rdata;
      keep_err = s_next.slverr;
      s_next = ST_RST; // [RQ10]
      s_next.err_n = 1'b0; // [RQ10]
      s_next.rdata = keep_rdata;
      s_next.slverr = keep_err;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ********
  // Outputs
  // ********
  assign PRDATA_O = s_reg.rdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = s_reg.slverr;
  assign GATE_O = s_reg.gates;
  assign ERROR_INDICATOR_N_O = s_reg.err_n;

  // ********
  // Assertions
  // ********
  logic [TIMER_W-1:0] lim_run_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (int_rst || !(limit_q && active)) begin
      lim_run_reg <= '0;
    end else if (lim_run_reg != '1) begin
      lim_run_reg <= lim_run_reg + 1'b1;
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (int_rst);

  AST_LIMIT_STEP: assert property ( // [RQ1]
    limit_q && pwm_wrap && s_reg.duty != '0 && (mode == MODE_FWD || mode == MODE_REV)
    |=> s_reg.duty == $past(s_reg.duty) - 8'h01)
    else $error("duty not lowered under limit");

  AST_CLF_DELAY: assert property ( // [RQ2]
    clf == (lim_run_reg >= TIMER_W'(CLF_FAULT_CYC)))
    else $error("limit fault timing wrong");

  AST_CLF_RUNS: assert property ( // [RQ3]
    clf && mode == MODE_FWD && !ovc_set && !therm_q |=> s_reg.gates != GATE_OFF)
    else $error("bridge stopped under limit fault");

  AST_CLF_CLEAR: assert property ( // [RQ4]
    !limit_q |=> !clf)
    else $error("limit fault not self cleared");

  AST_OVC_OFF: assert property ( // [RQ5]
    s_reg.ovc_latch |-> s_reg.gates == GATE_OFF && !s_reg.err_n)
    else $error("bridge on during overcurrent");

  AST_OVC_HOLD: assert property ( // [RQ6]
    s_reg.ovc_latch |=> s_reg.ovc_latch)
    else $error("overcurrent latch released");

  AST_OVC_SRC: assert property ( // [RQ7]
    ovc_hit != '0 |=> s_reg.ovc_latch && (s_reg.ovc_src & $past(ovc_hit)) == $past(ovc_hit))
    else $error("clamp source not latched");

  AST_THERM_OFF: assert property ( // [RQ9]
    therm_q |=> s_reg.gates == GATE_OFF && !s_reg.err_n)
    else $error("bridge on during over temperature");

  AST_LOCKOUT: assert property ( // [RQ10]
    @(posedge SYS_CLK_I) disable iff (RST_I)
    low_q |=> s_reg.gates == GATE_OFF && !s_reg.err_n && !s_reg.ovc_latch && s_reg.duty == '0)
    else $error("lockout did not reset");

  AST_SLEEP_OFF: assert property ( // [RQ11]
    mode == MODE_SLEEP |=> s_reg.gates == GATE_OFF)
    else $error("gates on in sleep");

  AST_SLEEP_CLEAR: assert property ( // [RQ15]
    mode == MODE_SLEEP |=> !clf)
    else $error("sleep kept limit fault");

  AST_WAKE_PULSE: assert property ( // [RQ16]
    active && !s_reg.active_d |=> !s_reg.err_n [*8])
    else $error("no wake pulse");

  AST_RAMP_ZERO: assert property ( // [RQ17]
    mode == MODE_SLEEP || mode == MODE_BRAKE |=> s_reg.duty == '0)
    else $error("duty not restarted");
endmodule

// *** sim/mbfs_host_model.sv ***
`timescale 1ns/1ps
module mbfs_host_model
  import mbfs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Supply state and command
  input wire logic supply_low_i,
  input wire logic [1:0] mode_i,
  // Device pins
  input wire logic error_indicator_n_i,
  output logic direction_input_a_o,
  output logic direction_input_b_o,
  // Length of the last low run of the indicator
  output logic [15:0] last_low_o
);
  logic [15:0] run;
  logic prev;

  initial begin
    direction_input_a_o = 1'b0;
    direction_input_b_o = 1'b0;
    last_low_o = 16'h0;
    run = 16'h0;
    prev = 1'b1;
  end

  // Both direction pins low while the supply is off
  always @(posedge clk_i) begin
    direction_input_a_o <= !supply_low_i && mode_i[0];
    direction_input_b_o <= !supply_low_i && mode_i[1];
    prev <= error_indicator_n_i;
    run <= error_indicator_n_i ? 16'h0 : run + 16'h1;
    if (error_indicator_n_i && !prev) begin
      last_low_o <= run;
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb
  import mbfs_pkg::*;
();
  // ****
  // Signals
  // ****
  localparam int CLF = 200;
  localparam int TICK = 4;
  localparam int RAMP_WAIT = 256 * TICK + 60;
  logic clk, rst, psel, pen, pwr, sense, therm, slow, pready, pslverr, dir_a, dir_b, ind, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] clamp, gates;
  logic [1:0] mode;
  logic [15:0] last_low, lfsr;
  int errors, checks, cyc, n;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  mbfs_top #(.CLF_FAULT_CYC(CLF), .RAMP_TICK_CYC(TICK)) DUT (
    .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DIRECTION_INPUT_A_I(dir_a), .DIRECTION_INPUT_B_I(dir_b),
    .CURRENT_SENSE_NODE_I(sense), .FET_CLAMP_I(clamp), .THERMAL_SHUTDOWN_I(therm),
    .SUPPLY_LOW_LOCKOUT_I(slow), .GATE_O(gates), .ERROR_INDICATOR_N_O(ind)
  );

  mbfs_host_model host (
    .clk_i(clk), .supply_low_i(slow), .mode_i(mode), .error_indicator_n_i(ind),
    .direction_input_a_o(dir_a), .direction_input_b_o(dir_b), .last_low_o(last_low)
  );

  // ****
  // Tasks
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] gate_for(input logic [1:0] m);
    case (m)
      MODE_FWD: return {28'h0, GATE_FWD};
      MODE_REV: return {28'h0, GATE_REV};
      MODE_BRAKE: return {28'h0, GATE_BRAKE};
      default: return {28'h0, GATE_OFF};
    endcase
  endfunction

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cw(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cf(input string nm, input logic g);
    cw(nm, 32'h1, {31'h0, g});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    cw("apb wait", 32'h1, k);
  endtask

  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic go(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
  endtask

  task automatic wait_ind(input logic l, input int lim);
    #1;
    n = 0;
    while (ind !== l && n < lim) begin
      tick(1);
      n++;
    end
    cw("indicator", {31'h0, l}, {31'h0, ind});
  endtask

  task automatic wake(input logic [1:0] m);
    go(m);
    wait_ind(1'b0, 20);
    wait_ind(1'b1, 300);
    tick(1);
    cw("wake pulse", 32'(WAKE_PULSE_CYC), {16'h0, last_low});
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      complete_run;
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    {rst, psel, pen, pwr, sense, therm, slow} = 7'h40;
    paddr = 8'h0;
    pwdata = 32'h0;
    clamp = 4'h0;
    mode = MODE_SLEEP;
    // Seed 17423
    lfsr = 16'h440f;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    cw("gates", gate_for(MODE_SLEEP), {28'h0, gates});
    cf("indicator", ind);
    rdreg(REG_CTRL_OFS);
    cw("ctrl", 32'hff, rd);
    rdreg(REG_STATUS_OFS);
    cw("status", 32'h0, rd);
    apb(1'b1, 8'h0c, 32'h1);
    cf("slverr", er);
    $display("test reset done");
    for (int m = 1; m < 4; m++) begin
      wake(m[1:0]);
      tick(RAMP_WAIT);
      cw("gates", gate_for(m[1:0]), {28'h0, gates});
      rdreg(REG_DUTY_OFS);
      cw("duty", (m == 3) ? 32'h0 : 32'hff, rd);
      go(MODE_SLEEP);
      tick(6);
      cw("gates", gate_for(MODE_SLEEP), {28'h0, gates});
    end
    $display("test modes done");
    wake(MODE_FWD);
    tick(RAMP_WAIT);
    @(posedge clk);
    sense <= 1'b1;
    tick(300);
    @(posedge clk);
    sense <= 1'b0;
    tick(3000);
    rdreg(REG_DUTY_OFS);
    cw("duty", 32'hff, rd);
    @(posedge clk);
    sense <= 1'b1;
    wait_ind(1'b0, 1000);
    cf("fault delay", n >= ILIM_FILTER_CYC + CLF);
    cf("bridge on", gates === GATE_FWD || gates === GATE_RECIRC);
    tick(6000);
    rdreg(REG_DUTY_OFS);
    cf("duty lowered", rd[7:0] < 8'hff);
    rdreg(REG_STATUS_OFS);
    cw("status", 32'h181, rd);
    @(posedge clk);
    sense <= 1'b0;
    wait_ind(1'b1, 20);
    @(posedge clk);
    sense <= 1'b1;
    wait_ind(1'b0, 1000);
    go(MODE_SLEEP);
    wait_ind(1'b1, 20);
    rdreg(REG_STATUS_OFS);
    cf("fault cleared", rd[STAT_CLF_BIT] === 1'b0);
    @(posedge clk);
    sense <= 1'b0;
    $display("test current limit done");
    wake(MODE_FWD);
    tick(RAMP_WAIT);
    @(posedge clk);
    therm <= 1'b1;
    tick(6);
    cw("gates", gate_for(MODE_SLEEP), {28'h0, gates});
    cf("indicator low", ind === 1'b0);
    rdreg(REG_STATUS_OFS);
    cw("status", 32'h140, rd);
    @(posedge clk);
    therm <= 1'b0;
    tick(6);
    cf("bridge on", gates === GATE_FWD || gates === GATE_RECIRC);
    cf("indicator", ind);
    go(MODE_SLEEP);
    $display("test thermal done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_CTRL_OFS, 32'h5a);
      wake(MODE_FWD);
      @(posedge clk);
      clamp <= 4'h1 << i;
      tick(OVC_FILTER_CYC - 50);
      @(posedge clk);
      clamp <= 4'h0;
      tick(6);
      cf("indicator", ind);
      @(posedge clk);
      clamp <= 4'h1 << i;
      tick(OVC_FILTER_CYC + 10);
      @(posedge clk);
      clamp <= 4'h0;
      tick(6);
      cw("gates", gate_for(MODE_SLEEP), {28'h0, gates});
      cf("indicator low", ind === 1'b0);
      rdreg(REG_STATUS_OFS);
      cf("latch", rd[STAT_OVC_BIT]);
      cf("source", rd[STAT_SRC_LSB + i]);
      go(MODE_REV);
      tick(10);
      cw("gates", gate_for(MODE_SLEEP), {28'h0, gates});
      cf("indicator low", ind === 1'b0);
      @(posedge clk);
      slow <= 1'b1;
      tick(6);
      cf("indicator low", ind === 1'b0);
      rdreg(REG_STATUS_OFS);
      cf("supply low", rd[STAT_LOW_BIT]);
      go(MODE_SLEEP);
      slow <= 1'b0;
      tick(6);
      rdreg(REG_STATUS_OFS);
      cw("status", 32'h0, rd);
      rdreg(REG_CTRL_OFS);
      cw("ctrl", 32'hff, rd);
    end
    $display("test overcurrent done");
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, REG_CTRL_OFS, {lfsr, lfsr});
      rdreg(REG_CTRL_OFS);
      cw("ctrl", {24'h0, lfsr[7:0]}, rd);
      rdreg((lfsr[15:8] | 8'h10) & 8'hfc);
      cf("slverr", er);
      cw("unmapped", 32'h0, rd);
    end
    apb(1'b1, REG_CTRL_OFS, {24'h0, lfsr[7:0] | 8'h10});
    go(MODE_FWD);
    tick(8);
    rdreg(REG_DUTY_OFS);
    cf("duty start", rd < 32'h4);
    tick(RAMP_WAIT);
    rdreg(REG_DUTY_OFS);
    cw("duty", {24'h0, lfsr[7:0] | 8'h10}, rd);
    $display("test random done");
    complete_run;
  end
endmodule
